// ===== btta_bus_model.sv
// emulated processor bus seen through the probe
// assumes: bench calls run from its main process; drives at falling edge
`timescale 1ns/1ps
`default_nettype none
module btta_bus_model (
	// clock
	input  wire logic        clk,
	// probe side
	output var  logic        cyc_valid,
	output var  logic [31:0] bus_addr,
	output wire logic [31:0] bus_data,
	output wire logic [47:0] bus_ctrl,
	output wire logic [7:0]  aux_in,
	output wire logic        ext_in,
	output wire logic [2:0]  hw_bkpt_hit
);
	// everything follows the address, so a released bus keeps toggling
	assign bus_data    = ~bus_addr;
	assign bus_ctrl    = {16'h0, bus_addr};
	assign aux_in      = bus_addr[7:0];
	assign ext_in      = bus_addr[1];
	assign hw_bkpt_hit = bus_addr[4:2];
	initial begin
		cyc_valid = 1'h0;
		bus_addr = 32'h0;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic run(input int n, input logic slow);
		for (int i = 0; i < n; i++) begin
			@(negedge clk);
			cyc_valid = 1'h1;
			bus_addr = 32'h100 + i;
			if (slow) begin
				@(negedge clk);
				cyc_valid = 1'h0;
				bus_addr = ~bus_addr;
			end
		end
		@(negedge clk);
		cyc_valid = 1'h0;
		bus_addr = ~bus_addr;
	endtask
endmodule
`default_nettype wire

// ===== btta_defines.vh
// constants shared by the bus trace and trigger analyzer files
// assumes: included by bare name from the top-level design file only
`ifndef BTTA_DEFINES_VH
`define BTTA_DEFINES_VH

`define BTTA_ADDR_W      32
`define BTTA_DATA_W      32
`define BTTA_CTRL_W      48
`define BTTA_AUX_W       8
`define BTTA_TERM_W      120
`define BTTA_CTRL_KEPT   39
`define BTTA_TAG_W       32
`define BTTA_TRACE_W     144
`define BTTA_TRACE_DEPTH 4096
`define BTTA_TRACE_AW    12
`define BTTA_SMALL_DEPTH 1024
`define BTTA_BLK_W       4
`define BTTA_OCC_W       8
`define BTTA_POST_W      16
`define BTTA_STAGES      3
`define BTTA_BKPTS       3
`define BTTA_HIST_N      16
`define BTTA_HIST_W      32
`define BTTA_FIFO_DEPTH  16
`define BTTA_FIFO_AW     4

`define BTTA_MODE_CONT   1'b0
`define BTTA_MODE_TRIG   1'b1
`define BTTA_POST_EVENTS 1'b0
`define BTTA_POST_CYCLES 1'b1

`define BTTA_ST_IDLE     2'h0
`define BTTA_ST_ARM      2'h1
`define BTTA_ST_POST     2'h2
`define BTTA_ST_DONE     2'h3

`endif

// ===== btta_fifo.v
// small synchronous fifo between capture and trace memory
// assumes: one clock; a push while full is dropped, sink may stall
`timescale 1ns/1ps
`default_nettype none
module btta_fifo #(
	parameter W     = 148,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	// clock and reset
	input  wire         clk,
	input  wire         reset_n,
	// fill side
	input  wire         in_valid,
	output wire         in_ready,
	input  wire [W-1:0] in_data,
	// drain side
	output wire         out_valid,
	input  wire         out_ready,
	output wire [W-1:0] out_data
);
	reg  [W-1:0] mem [0:DEPTH-1];
	reg  [AW-1:0] wp_ff;
	reg  [AW-1:0] rp_ff;
	reg  [AW:0]   cnt_ff;
	reg           full_ff;
	reg           empty_ff;
	reg  [AW:0]   nxt_cnt;
	wire          push;
	wire          pop;

	assign in_ready  = ~full_ff;
	assign out_valid = ~empty_ff;
	assign out_data  = mem[rp_ff];
	assign push      = in_valid & ~full_ff;
	assign pop       = out_ready & ~empty_ff;

	always @* begin
		nxt_cnt = cnt_ff;
		if (push & ~pop)
			nxt_cnt = cnt_ff + {{AW{1'b0}}, 1'b1};
		else if (pop & ~push)
			nxt_cnt = cnt_ff - {{AW{1'b0}}, 1'b1};
	end

	always @(posedge clk) begin
		if (push)
			mem[wp_ff] <= in_data;
	end

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wp_ff    <= {AW{1'b0}};
			rp_ff    <= {AW{1'b0}};
			cnt_ff   <= {(AW+1){1'b0}};
			full_ff  <= 1'b0;
			empty_ff <= 1'b1;
		end else begin
			if (push)
				wp_ff <= wp_ff + {{(AW-1){1'b0}}, 1'b1};
			if (pop)
				rp_ff <= rp_ff + {{(AW-1){1'b0}}, 1'b1};
			cnt_ff   <= nxt_cnt;
			full_ff  <= (nxt_cnt == DEPTH[AW:0]);
			empty_ff <= (nxt_cnt == {(AW+1){1'b0}});
		end
	end
endmodule
`default_nettype wire

// ===== btta_match.v
// masked level compare of the probe term vector against a pattern
// assumes: mask bit high means the term takes part in the compare
`timescale 1ns/1ps
`default_nettype none
module btta_match #(
	parameter W = 120
) (
	// terms and pattern
	input  wire [W-1:0] terms,
	input  wire [W-1:0] value,
	input  wire [W-1:0] mask,
	// result
	output wire         hit
);
	// all-zero mask matches every cycle
	assign hit = ~|((terms ^ value) & mask);
endmodule
`default_nettype wire

// ===== btta_top.v
// bus trace capture, trigger sequencing, time tags and histogram counts
// assumes: bus probe gives one cyc_valid pulse per bus cycle, synchronous to clk
// Contract
// - continuous mode stores every cycle until stop
// - triggered mode records N events or cycles after trigger; code records up to and including the (N+1)th
// - trigger is masked level match on bus lines
// - eight aux plus external input traced and triggerable
// - external trigger output pulses on each trigger
// - enabled trigger requests emulator halt
// - store all cycles or only qualified ones
// - staged triggers, later stage armed after earlier fires
// - small variant trace depth 1024 entries
// - histogram counts over 16 address ranges
// - optional halt on every recorded cycle
// - 112 bus terms plus eight user inputs
// - each entry carries a 32-bit time tag
// - complex event adds external, timer, three breakpoints
// - wide trace memory 144 bits by 4096
// - up to 16 blocks, occurrence 1..256 triggers
// - event term enables change while running
// - each block is a sliding window buffer
`timescale 1ns/1ps
`default_nettype none
`include "btta_defines.vh"
module btta_top #(
	parameter DEPTH = `BTTA_TRACE_DEPTH,
	parameter AW    = `BTTA_TRACE_AW
) (
	// clock and reset
	input  wire                              clk,
	input  wire                              reset_n,
	// emulated bus through the probe
	input  wire                              cyc_valid,
	input  wire [`BTTA_ADDR_W-1:0]           bus_addr,
	input  wire [`BTTA_DATA_W-1:0]           bus_data,
	input  wire [`BTTA_CTRL_W-1:0]           bus_ctrl,
	input  wire [`BTTA_AUX_W-1:0]            aux_in,
	input  wire                              ext_in,
	input  wire [`BTTA_BKPTS-1:0]            hw_bkpt_hit,
	// run control
	input  wire                              run_start,
	input  wire                              run_stop,
	// configuration
	input  wire                              rec_mode,
	input  wire                              qual_only,
	input  wire [`BTTA_TERM_W-1:0]           qual_value,
	input  wire [`BTTA_TERM_W-1:0]           qual_mask,
	input  wire [`BTTA_STAGES*`BTTA_TERM_W-1:0] stage_value,
	input  wire [`BTTA_STAGES*`BTTA_TERM_W-1:0] stage_mask,
	input  wire [1:0]                        stage_last,
	input  wire [`BTTA_OCC_W-1:0]            occ_sel,
	input  wire                              post_unit,
	input  wire [`BTTA_POST_W-1:0]           post_count,
	input  wire [2:0]                        blk_log2,
	input  wire                              ext_term_en,
	input  wire                              timer_term_en,
	input  wire [`BTTA_TAG_W-1:0]            timer_cmp,
	input  wire [`BTTA_BKPTS-1:0]            bkpt_term_en,
	input  wire                              halt_on_trig,
	input  wire                              halt_on_record,
	input  wire                              ovf_clr,
	// histogram
	input  wire [`BTTA_HIST_N*`BTTA_ADDR_W-1:0] hist_base,
	input  wire [`BTTA_ADDR_W-1:0]           hist_limit,
	input  wire                              hist_clr,
	input  wire [3:0]                        hist_sel,
	output reg  [`BTTA_HIST_W-1:0]           hist_data_ff,
	// trace readback
	input  wire                              rd_req,
	input  wire [AW-1:0]                     rd_addr,
	output reg                               rd_valid_ff,
	output reg  [`BTTA_TRACE_W-1:0]          rd_data_ff,
	// status and emulator control
	output reg                               trig_out_ff,
	output reg                               halt_req_ff,
	output reg                               running_ff,
	output reg                               done_ff,
	output reg  [`BTTA_BLK_W-1:0]            blk_ff,
	output reg                               overflow_ff
);
	localparam FW = `BTTA_TRACE_W + `BTTA_BLK_W;

	////////////////////////////////////////////////////////////////////
	reg  [`BTTA_TRACE_W-1:0] mem [0:DEPTH-1];
	reg  [1:0]               state_ff;
	reg  [1:0]               stage_ff;
	reg  [`BTTA_OCC_W-1:0]   occ_ff;
	reg  [`BTTA_POST_W-1:0]  post_ff;
	reg  [`BTTA_TAG_W-1:0]   timer_ff;
	reg  [AW-1:0]            wptr_ff;
	reg  [`BTTA_BLK_W-1:0]   last_blk_ff;
	reg                      restart_ff;
	wire [`BTTA_TERM_W-1:0]  terms;
	wire [`BTTA_STAGES:0]    bus_hit;
	wire [`BTTA_STAGES-1:0]  cplx_hit;
	wire                     extra_ok;
	wire                     fire;
	wire                     final_stage;
	wire                     trig;
	wire                     post_step;
	wire                     blk_end;
	wire                     record;
	wire                     f_in_ready;
	wire                     f_valid;
	wire [FW-1:0]            f_data;
	wire [FW-1:0]            f_in;
	wire                     wr_en;

	// 112 bus terms plus eight user lines
	assign terms = {aux_in, bus_ctrl, bus_data, bus_addr};

	////////////////////////////////////////////////////////////////////
	// stage matchers plus the qualifier at index STAGES
	genvar gi;
	generate
		for (gi = 0; gi <= `BTTA_STAGES; gi = gi + 1) begin : g_match
			if (gi < `BTTA_STAGES) begin : g_stage
				btta_match #(.W(`BTTA_TERM_W)) u_match (
					.terms (terms),
					.value (stage_value[gi*`BTTA_TERM_W +: `BTTA_TERM_W]),
					.mask  (stage_mask[gi*`BTTA_TERM_W +: `BTTA_TERM_W]),
					.hit   (bus_hit[gi])
				);
				assign cplx_hit[gi] = bus_hit[gi] & extra_ok;
			end else begin : g_qual
				btta_match #(.W(`BTTA_TERM_W)) u_match (
					.terms (terms),
					.value (qual_value),
					.mask  (qual_mask),
					.hit   (bus_hit[gi])
				);
			end
		end
	endgenerate

	// enables are live ports, so software may flip them mid-run
	assign extra_ok = (~ext_term_en | ext_in) &
		(~timer_term_en | (timer_ff >= timer_cmp)) &
		(&(~bkpt_term_en | hw_bkpt_hit));

	assign final_stage = (stage_ff >= stage_last);
	assign fire = running_ff & cyc_valid & (state_ff == `BTTA_ST_ARM) &
		(rec_mode == `BTTA_MODE_TRIG) & cplx_hit[stage_ff];
	// occ_sel of zero selects the 256th occurrence
	assign trig = fire & final_stage &
		(occ_ff == occ_sel - {{(`BTTA_OCC_W-1){1'b0}}, 1'b1});

	assign post_step = (state_ff == `BTTA_ST_POST) & cyc_valid &
		((post_unit == `BTTA_POST_CYCLES) | cplx_hit[stage_last]);
	assign blk_end = post_step & (post_ff == {`BTTA_POST_W{1'b0}});

	assign record = running_ff & cyc_valid & (~qual_only | bus_hit[`BTTA_STAGES]) &
		((rec_mode == `BTTA_MODE_CONT) | trig | (state_ff == `BTTA_ST_POST));

	////////////////////////////////////////////////////////////////////
	// trigger sequencer
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff    <= `BTTA_ST_IDLE;
			stage_ff    <= 2'h0;
			occ_ff      <= {`BTTA_OCC_W{1'b0}};
			post_ff     <= {`BTTA_POST_W{1'b0}};
			blk_ff      <= {`BTTA_BLK_W{1'b0}};
			running_ff  <= 1'b0;
			done_ff     <= 1'b0;
			trig_out_ff <= 1'b0;
			halt_req_ff <= 1'b0;
			timer_ff    <= {`BTTA_TAG_W{1'b0}};
		end else begin
			trig_out_ff <= trig;
			halt_req_ff <= (trig & halt_on_trig) | (record & halt_on_record);
			timer_ff    <= run_start ? {`BTTA_TAG_W{1'b0}} :
				timer_ff + {{(`BTTA_TAG_W-1){1'b0}}, 1'b1};
			if (run_start) begin
				state_ff   <= `BTTA_ST_ARM;
				stage_ff   <= 2'h0;
				occ_ff     <= {`BTTA_OCC_W{1'b0}};
				blk_ff     <= {`BTTA_BLK_W{1'b0}};
				running_ff <= 1'b1;
				done_ff    <= 1'b0;
			end else if (run_stop) begin
				// manual stop ends any mode; breakpoint hits only feed the complex event
				state_ff   <= `BTTA_ST_IDLE;
				running_ff <= 1'b0;
			end else begin
				case (state_ff)
				`BTTA_ST_ARM: begin
					if (fire & ~final_stage)
						stage_ff <= stage_ff + 2'h1;
					else if (trig) begin
						state_ff <= `BTTA_ST_POST;
						post_ff  <= post_count;
					end else if (fire)
						occ_ff <= occ_ff + {{(`BTTA_OCC_W-1){1'b0}}, 1'b1};
				end
				`BTTA_ST_POST: begin
					if (blk_end) begin
						if ({1'b0, blk_ff} == ((5'h01 << blk_log2) - 5'h01)) begin
							state_ff   <= `BTTA_ST_DONE;
							running_ff <= 1'b0;
							done_ff    <= 1'b1;
						end else begin
							blk_ff   <= blk_ff + {{(`BTTA_BLK_W-1){1'b0}}, 1'b1};
							state_ff <= `BTTA_ST_ARM;
							stage_ff <= 2'h0;
							occ_ff   <= {`BTTA_OCC_W{1'b0}};
						end
					end else if (post_step)
						post_ff <= post_ff - {{(`BTTA_POST_W-1){1'b0}}, 1'b1};
				end
				`BTTA_ST_IDLE: begin
				end
				`BTTA_ST_DONE: begin
				end
				default: state_ff <= `BTTA_ST_IDLE;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// capture path; the bus cannot be stalled, so a full fifo drops and flags
	assign f_in = {blk_ff, timer_ff, ext_in, aux_in, bus_ctrl[`BTTA_CTRL_KEPT-1:0],
		bus_data, bus_addr};

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			overflow_ff <= 1'b0;
		else if (record & ~f_in_ready)
			overflow_ff <= 1'b1;
		else if (ovf_clr)
			overflow_ff <= 1'b0;
	end

	btta_fifo #(.W(FW), .DEPTH(`BTTA_FIFO_DEPTH), .AW(`BTTA_FIFO_AW)) u_fifo (
		.clk       (clk),
		.reset_n   (reset_n),
		.in_valid  (record),
		.in_ready  (f_in_ready),
		.in_data   (f_in),
		.out_valid (f_valid),
		.out_ready (~rd_req),
		.out_data  (f_data)
	);

	////////////////////////////////////////////////////////////////////
	// trace memory; readback has priority over fifo drain
	function [AW-1:0] blk_addr;
		input [`BTTA_BLK_W-1:0] blk;
		input [AW-1:0]          ptr;
		input [2:0]             lg;
		reg   [AW-1:0]          msk;
		begin
			msk      = {AW{1'b1}} >> lg;
			blk_addr = ({{(AW-`BTTA_BLK_W){1'b0}}, blk} << (AW - lg)) | (ptr & msk);
		end
	endfunction

	wire [`BTTA_BLK_W-1:0] f_blk   = f_data[FW-1 -: `BTTA_BLK_W];
	wire                   new_blk = restart_ff | (f_blk != last_blk_ff);
	wire [AW-1:0]          ptr_use = new_blk ? {AW{1'b0}} : wptr_ff;
	assign wr_en = f_valid & ~rd_req;

	always @(posedge clk) begin
		if (wr_en)
			mem[blk_addr(f_blk, ptr_use, blk_log2)] <= f_data[`BTTA_TRACE_W-1:0];
	end

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wptr_ff     <= {AW{1'b0}};
			last_blk_ff <= {`BTTA_BLK_W{1'b0}};
			restart_ff  <= 1'b1;
			rd_valid_ff <= 1'b0;
			rd_data_ff  <= {`BTTA_TRACE_W{1'b0}};
		end else begin
			rd_valid_ff <= rd_req;
			if (rd_req)
				rd_data_ff <= mem[rd_addr];
			if (run_start)
				restart_ff <= 1'b1;
			else if (wr_en) begin
				restart_ff  <= 1'b0;
				last_blk_ff <= f_blk;
				// wraps within its block, oldest entry overwritten
				wptr_ff     <= (ptr_use + {{(AW-1){1'b0}}, 1'b1}) & ({AW{1'b1}} >> blk_log2);
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// histogram: range i spans base i up to base i+1, last up to limit
	wire [`BTTA_HIST_N*`BTTA_HIST_W-1:0] hist_all;
	generate
		for (gi = 0; gi < `BTTA_HIST_N; gi = gi + 1) begin : g_hist
			wire [`BTTA_ADDR_W-1:0] lo = hist_base[gi*`BTTA_ADDR_W +: `BTTA_ADDR_W];
			wire [`BTTA_ADDR_W-1:0] hi;
			reg  [`BTTA_HIST_W-1:0] cnt_ff;
			if (gi == `BTTA_HIST_N-1) begin : g_last
				assign hi = hist_limit;
			end else begin : g_mid
				assign hi = hist_base[(gi+1)*`BTTA_ADDR_W +: `BTTA_ADDR_W];
			end
			always @(posedge clk or negedge reset_n) begin
				if (!reset_n)
					cnt_ff <= {`BTTA_HIST_W{1'b0}};
				else if (hist_clr)
					cnt_ff <= {`BTTA_HIST_W{1'b0}};
				else if (running_ff & cyc_valid & (bus_addr >= lo) & (bus_addr < hi) &
					~&cnt_ff)
					cnt_ff <= cnt_ff + {{(`BTTA_HIST_W-1){1'b0}}, 1'b1};
			end
			assign hist_all[gi*`BTTA_HIST_W +: `BTTA_HIST_W] = cnt_ff;
		end
	endgenerate

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			hist_data_ff <= {`BTTA_HIST_W{1'b0}};
		else
			hist_data_ff <= hist_all[hist_sel*`BTTA_HIST_W +: `BTTA_HIST_W];
	end
endmodule
`default_nettype wire

// ===== btta_top_assertions.sv
// port checker for btta_top: trigger, halt, run state and readback timing
// assumes: bound to btta_top, single clk domain, reset_n async active low
`timescale 1ns/1ps
`default_nettype none
module btta_chk (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// inputs watched
	input wire logic cyc_valid,
	input wire logic run_start,
	input wire logic run_stop,
	input wire logic rec_mode,
	input wire logic halt_on_trig,
	input wire logic halt_on_record,
	input wire logic ovf_clr,
	input wire logic rd_req,
	// outputs watched
	input wire logic rd_valid_ff,
	input wire logic trig_out_ff,
	input wire logic halt_req_ff,
	input wire logic running_ff,
	input wire logic done_ff,
	input wire logic overflow_ff
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_rd_ans;
		##1 rd_valid_ff;
	endsequence
	sequence s_run_up;
		##1 (running_ff && !done_ff);
	endsequence
	property p_rd_ans;
		rd_req |-> s_rd_ans;
	endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read answer missing");
	property p_rd_only;
		!rd_req |=> !rd_valid_ff;
	endproperty
	a_rd_only: assert property (p_rd_only) else $error("read valid without request");
	// continuous mode never triggers, idle cycles never trigger
	property p_trig_cause;
		trig_out_ff |-> $past(cyc_valid) && $past(running_ff) && $past(rec_mode);
	endproperty
	a_trig_cause: assert property (p_trig_cause) else $error("trigger without cause");
	property p_trig_pulse;
		trig_out_ff |=> !trig_out_ff;
	endproperty
	a_trig_pulse: assert property (p_trig_pulse) else $error("trigger wider than one clk");
	property p_halt_trig;
		trig_out_ff && $past(halt_on_trig) |-> halt_req_ff;
	endproperty
	a_halt_trig: assert property (p_halt_trig) else $error("trigger did not halt");
	property p_halt_cause;
		halt_req_ff |-> $past(halt_on_trig) || $past(halt_on_record);
	endproperty
	a_halt_cause: assert property (p_halt_cause) else $error("halt while disabled");
	property p_stop;
		run_stop && !run_start |=> !running_ff;
	endproperty
	a_stop: assert property (p_stop) else $error("still running after stop");
	property p_start;
		run_start |-> s_run_up;
	endproperty
	a_start: assert property (p_start) else $error("run did not start");
	property p_done;
		done_ff |-> !running_ff && ($stable(done_ff) || ($past(running_ff) && $past(rec_mode)));
	endproperty
	a_done: assert property (p_done) else $error("done while running");
	property p_ovf;
		overflow_ff && !ovf_clr |=> overflow_ff;
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow flag lost");
endmodule
`default_nettype wire

// ===== btta_top_bench.sv
// self-checking bench for btta_top with bus model and port checker
// assumes: btta_top, btta_bus_model and btta_chk compiled before it
`timescale 1ns/1ps
`default_nettype none
module btta_top_bench;
	typedef struct packed {
		logic m, q, x; logic [1:0] l; logic [7:0] o; logic [2:0] b; logic [8:0] n;
		logic [31:0] v0, m0, m1, e0, e1; logic t, h;
	} btta_row_t;
	logic clk, reset_n, run_start, run_stop, rec_mode, qual_only, ext_term_en;
	logic halt_on_trig, ovf_clr, hist_clr, rd_req, post_unit, halt_on_record, timer_term_en;
	logic [119:0] qual_value, qual_mask;
	logic [359:0] stage_value, stage_mask;
	logic [1:0] stage_last;
	logic [7:0] occ_sel;
	logic [15:0] post_count;
	logic [2:0] blk_log2, bkpt_term_en;
	logic [511:0] hist_base;
	logic [31:0] hist_limit, t0, timer_cmp;
	logic [3:0] hist_sel;
	logic [11:0] rd_addr;
	logic [143:0] d;
	wire [31:0] hist_data_ff, bus_addr, bus_data;
	wire [143:0] rd_data_ff;
	wire [47:0] bus_ctrl;
	wire [7:0] aux_in;
	wire [3:0] blk_ff;
	wire [2:0] hw_bkpt_hit;
	wire rd_valid_ff, trig_out_ff, halt_req_ff, running_ff, done_ff, overflow_ff;
	wire cyc_valid, ext_in;
	int failures, cmp_count, trig_n, halt_n;
	btta_row_t rows [8];
	btta_row_t r;
	btta_bus_model bus_model (.clk(clk), .cyc_valid(cyc_valid), .bus_addr(bus_addr),
		.bus_data(bus_data), .bus_ctrl(bus_ctrl), .aux_in(aux_in), .ext_in(ext_in),
		.hw_bkpt_hit(hw_bkpt_hit));
	btta_top uut (.clk(clk), .reset_n(reset_n), .cyc_valid(cyc_valid), .bus_addr(bus_addr),
		.bus_data(bus_data), .bus_ctrl(bus_ctrl), .aux_in(aux_in), .ext_in(ext_in),
		.hw_bkpt_hit(hw_bkpt_hit), .run_start(run_start), .run_stop(run_stop),
		.rec_mode(rec_mode), .qual_only(qual_only), .qual_value(qual_value),
		.qual_mask(qual_mask), .stage_value(stage_value), .stage_mask(stage_mask),
		.stage_last(stage_last), .occ_sel(occ_sel), .post_unit(post_unit),
		.post_count(post_count), .blk_log2(blk_log2), .ext_term_en(ext_term_en),
		.timer_term_en(timer_term_en), .timer_cmp(timer_cmp), .bkpt_term_en(bkpt_term_en),
		.halt_on_trig(halt_on_trig), .halt_on_record(halt_on_record), .ovf_clr(ovf_clr),
		.hist_base(hist_base), .hist_limit(hist_limit), .hist_clr(hist_clr),
		.hist_sel(hist_sel), .hist_data_ff(hist_data_ff), .rd_req(rd_req),
		.rd_addr(rd_addr), .rd_valid_ff(rd_valid_ff), .rd_data_ff(rd_data_ff),
		.trig_out_ff(trig_out_ff), .halt_req_ff(halt_req_ff), .running_ff(running_ff),
		.done_ff(done_ff), .blk_ff(blk_ff), .overflow_ff(overflow_ff));
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	// pulses counted mid-cycle, away from the edge that launches them
	always @(negedge clk) begin
		if (trig_out_ff === 1'h1) trig_n++;
		if (halt_req_ff === 1'h1) halt_n++;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic go(input int n, input logic s);
		tick(1); run_start = 1'h1; trig_n = 0; halt_n = 0;
		tick(1); run_start = 1'h0;
		bus_model.run(n, s);
	endtask
	// no fifo-empty port, so allow far more than 16 drains after stop
	task automatic stop;
		run_stop = 1'h1; tick(1); run_stop = 1'h0; tick(40);
	endtask
	task automatic rd(input logic [11:0] a);
		rd_req = 1'h1; rd_addr = a; tick(1); rd_req = 1'h0;
		chk("read valid", 1, rd_valid_ff);
		d = rd_data_ff; tick(1);
	endtask
	initial begin
		#400000 failures++;
		report_and_stop;
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		{run_start, run_stop, rec_mode, qual_only, ext_term_en, halt_on_trig} = 0;
		{ovf_clr, hist_clr, rd_req, stage_value, stage_mask, stage_last, occ_sel} = 0;
		{blk_log2, hist_sel, rd_addr, failures, cmp_count} = 0;
		{halt_on_record, timer_term_en, bkpt_term_en, timer_cmp} = 0;
		post_unit = 1'h1;
		qual_value = 120'h1; qual_mask = 120'h1; post_count = 16'h8; hist_limit = 32'h120;
		for (int i = 0; i < 16; i++) hist_base[i*32 +: 32] = 32'h100 + 2 * i;
		rows[0] = '{0, 0, 0, 0, 1, 0, 24, 0, 0, 0, 32'h100, 32'h101, 0, 0};
		rows[1] = '{0, 1, 0, 0, 1, 0, 24, 0, 0, 0, 32'h101, 32'h103, 0, 0};
		rows[2] = '{1, 0, 0, 0, 1, 0, 24, 32'h105, '1, 0, 32'h105, 32'h106, 1, 1};
		rows[3] = '{1, 0, 0, 0, 3, 0, 24, 0, 3, 0, 32'h108, 32'h109, 1, 0};
		rows[4] = '{1, 0, 0, 1, 1, 0, 24, 32'h102, '1, 3, 32'h104, 32'h105, 1, 0};
		rows[5] = '{1, 1, 0, 0, 1, 0, 24, 32'h105, '1, 0, 32'h105, 32'h107, 1, 0};
		rows[6] = '{1, 0, 1, 0, 1, 0, 24, 1, 1, 0, 32'h103, 32'h104, 1, 0};
		rows[7] = '{0, 0, 0, 0, 1, 4, 300, 0, 0, 0, 32'h200, 32'h201, 0, 0};
		reset_n = 1'h0;
		tick(8); reset_n = 1'h1; tick(2);
		chk("idle outputs", 0, {running_ff, done_ff, overflow_ff, trig_out_ff, blk_ff});
		for (int i = 0; i < 8; i++) begin
			r = rows[i];
			{rec_mode, qual_only, ext_term_en, stage_last, occ_sel, blk_log2} =
				{r.m, r.q, r.x, r.l, r.o, r.b};
			stage_value[31:0] = r.v0; stage_mask[31:0] = r.m0; stage_mask[151:120] = r.m1;
			halt_on_trig = r.h;
			go(r.n, 1'h0); stop;
			rd(12'h0); t0 = d[143:112];
			chk("first entry", r.e0, d[31:0]);
			chk("data field", ~r.e0, d[63:32]);
			chk("aux ext field", {r.e0[1], r.e0[7:0]}, d[111:103]);
			rd(12'h1);
			chk("next entry", r.e1, d[31:0]);
			chk("tag advances", 1, d[143:112] > t0);
			chk("trigger seen", r.t, trig_n != 0);
			chk("halt seen", r.h, halt_n != 0);
			chk("stopped", 0, running_ff);
			$display("row %0d done", i);
		end
		{rec_mode, qual_only, ext_term_en, halt_on_trig, stage_value} = 0;
		rec_mode = 1'h1; occ_sel = 8'h2; post_count = 16'h0; stage_mask[151:120] = 32'h0;
		stage_mask[31:0] = 32'h3;
		go(240, 1'h0);
		chk("all blocks done", 1, {running_ff, done_ff});
		chk("last block", 15, blk_ff);
		tick(40); rd(12'h100);
		chk("block one entry", 32'h10C, d[31:0]);
		$display("block test done");
		rec_mode = 1'h0; blk_log2 = 3'h0; post_count = 16'h8; rd_req = 1'h1;
		go(24, 1'h0);
		chk("fifo overflow", 1, overflow_ff);
		rd_req = 1'h0; ovf_clr = 1'h1; tick(1); ovf_clr = 1'h0; stop;
		chk("overflow cleared", 0, overflow_ff);
		$display("overflow test done");
		hist_clr = 1'h1; tick(1); hist_clr = 1'h0;
		go(24, 1'h1); stop;
		hist_sel = 4'h3; tick(2);
		chk("range three count", 2, hist_data_ff);
		hist_sel = 4'hC; tick(2);
		chk("range twelve count", 0, hist_data_ff);
		$display("histogram test done");
		rec_mode = 1'h1; occ_sel = 8'h1; post_unit = 1'h0; post_count = 16'h1;
		halt_on_record = 1'h1; stage_value[31:0] = 32'h4; stage_mask[31:0] = 32'h7;
		go(24, 1'h0); stop; rd(12'h10);
		chk("last event entry", 32'h114, d[31:0]);
		chk("halt per record", 17, halt_n);
		$display("event count test done");
		post_unit = 1'h1; post_count = 16'h0; halt_on_record = 1'h0; stage_value[31:0] = 32'h0;
		stage_mask[31:0] = 32'h3; bkpt_term_en = 3'h4; timer_term_en = 1'h1;
		timer_cmp = 32'h20;
		go(56, 1'h0); stop; rd(12'h0);
		chk("complex trigger entry", 32'h130, d[31:0]);
		{bkpt_term_en, timer_term_en, rec_mode} = 0;
		$display("complex event test done");
		go(4, 1'h0);
		reset_n = 1'h0; tick(1);
		chk("running in reset", 0, running_ff);
		reset_n = 1'h1; tick(2);
		chk("idle after reset", 0, {running_ff, done_ff, overflow_ff, trig_out_ff, halt_req_ff, blk_ff});
		$display("reset test done");
		report_and_stop;
	end
endmodule
bind btta_top btta_chk u_chk (.clk(clk), .reset_n(reset_n), .cyc_valid(cyc_valid),
	.run_start(run_start), .run_stop(run_stop), .rec_mode(rec_mode),
	.halt_on_trig(halt_on_trig), .halt_on_record(halt_on_record), .ovf_clr(ovf_clr),
	.rd_req(rd_req), .rd_valid_ff(rd_valid_ff), .trig_out_ff(trig_out_ff),
	.halt_req_ff(halt_req_ff), .running_ff(running_ff), .done_ff(done_ff),
	.overflow_ff(overflow_ff));
`default_nettype wire
